/* File: dv/lamp_strap_model.sv */
`timescale 1ns/1ps
module lamp_strap_model
  import phy_ind_pkg::*;
#(
  parameter logic [4:0] STRAP = 5'h0A
) (
  // device side
  input  wire phy_ind_pkg::indicator_t drive_i,
  input  wire phy_ind_pkg::indicator_t oe_n_i,
  // pads and lamps
  output phy_ind_pkg::indicator_t      pad_o,
  output logic [4:0]                   lamp_lit_o
);
  // a released pad settles to its strap resistor, never to the last driven level
  assign pad_o      = (oe_n_i & STRAP) | (~oe_n_i & drive_i);
  // lamp lit only while the pad is sunk low
  assign lamp_lit_o = ~oe_n_i & ~drive_i;
endmodule : lamp_strap_model

/* File: dv/testbench.sv */
`timescale 1ns/1ps
module testbench;
  import phy_ind_pkg::*;
  // short counts so the run stays small
  localparam int         STRETCH = 20;
  localparam int         TICK    = 10;
  localparam int         HOLD    = 3;
  localparam logic [4:0] STRAP   = 5'h0A;

  logic        clk_sys_i   = 1'b0;
  logic        reset_n_i   = 1'b0;
  wb_req_t     req         = '0;
  wb_rsp_t     rsp;
  logic        ext_reset_n = 1'b1;
  logic        pd_pin      = 1'b0;
  logic [14:0] cfgpin      = '0;
  phy_status_t st          = '0;
  indicator_t  pad;
  indicator_t  ind;
  indicator_t  oe_n;
  logic        rcyc;
  logic        pd;
  logic [4:0]  seed;
  logic [9:0]  cfgpin_state;
  logic [4:0]  lamp;
  logic [31:0] q;
  int          fails       = 0;
  int          checks      = 0;

  always #2.5 clk_sys_i = ~clk_sys_i;

  phy_indicator_and_reset_control #(
    .RST_STRETCH_CYC(STRETCH),
    .MS_TICK_CYC    (TICK),
    .HOLD_MS        (HOLD)
  ) phy_indicator_and_reset_control_inst (
    .clk_sys_i                (clk_sys_i),
    .reset_n_i                (reset_n_i),
    .wb_req_i                 (req),
    .wb_rsp_o                 (rsp),
    .ext_reset_n_i            (ext_reset_n),
    .power_down_input_i       (pd_pin),
    .multilevel_config_input_i(cfgpin),
    .ind_i                    (pad),
    .ind_o                    (ind),
    .ind_oe_n_o               (oe_n),
    .phy_status_i             (st),
    .reset_cycle_o            (rcyc),
    .power_down_o             (pd),
    .scrambler_seed_o         (seed),
    .cfgpin_state_o           (cfgpin_state)
  );

  lamp_strap_model #(.STRAP(STRAP)) lamp_strap_model_inst (
    .drive_i   (ind),
    .oe_n_i    (oe_n),
    .pad_o     (pad),
    .lamp_lit_o(lamp)
  );

  task automatic stop_test();
    $display("checks %0d fails %0d", checks, fails);
    if (fails == 0 && checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : stop_test

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      fails++;
      $display("mismatch at %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic timeout();
    check(32'h0000_0000, 32'h0000_0001);
    stop_test();
  endtask : timeout

  task automatic cycles(input int n);
    repeat (n) @(posedge clk_sys_i);
  endtask : cycles

  // entered just after a rising edge; holds the request until ack is sampled
  task automatic wb(input logic [7:0] a, input logic w, input logic [3:0] s,
                    input logic [31:0] d);
    int n;
    n = 0;
    req <= '{cyc: 1'b1, stb: 1'b1, we: w, sel: s, adr: a, dat: d};
    do begin
      @(posedge clk_sys_i);
      n++;
    end while (rsp.ack !== 1'b1 && n < 50);
    if (n >= 50) timeout();
    q = rsp.dat;
    req <= '0;
    @(posedge clk_sys_i);
  endtask : wb

  task automatic wait_rcyc(input logic lvl, output int n);
    n = 0;
    while (rcyc !== lvl) begin
      @(posedge clk_sys_i);
      n++;
      if (n > 200) timeout();
    end
  endtask : wait_rcyc

  initial begin
    int         n;
    logic [7:0] stv [4];
    repeat (8) @(posedge clk_sys_i);
    reset_n_i <= 1'b1;
    wait_rcyc(1'b0, n);
    check(seed, STRAP);
    check(oe_n, 5'h00);
    ext_reset_n <= 1'b0;
    cycles(6);
    check(rcyc, 1'b1);
    check(oe_n, 5'h1F);
    ext_reset_n <= 1'b1;
    wait_rcyc(1'b0, n);
    check(n >= STRETCH && n <= STRETCH + 8, 1'b1);
    check(seed, STRAP);
    wb(CTRL_OFS, 1'b1, 4'hF, 32'h0000_8000);
    wait_rcyc(1'b1, n);
    wait_rcyc(1'b0, n);
    check(n >= STRETCH - 4 && n <= STRETCH + 8, 1'b1);
    wb(CTRL_OFS, 1'b0, 4'hF, 32'h0000_0000);
    check(q, 32'h0000_0000);
    $display("test reset done");

    stv = '{8'h88, 8'h8C, 8'h02, 8'h0C};
    for (int i = 0; i < 4; i++) begin
      st <= stv[i];
      cycles(4);
      check(ind.link_indicator_n, 1'(i == 0 || i == 3));
      check(ind.speed_indicator_n, 1'(i >= 2));
      if (i == 1) check(lamp, 5'h12);
    end
    stv = '{8'h40, 8'h20, 8'h00, 8'h00};
    for (int j = 0; j < 2; j++) begin
      st <= stv[j];
      cycles(1);
      st <= 8'h00;
      cycles(2);
      check(ind[3-j], 1'b0);
      cycles(TICK);
      check(ind[3-j], 1'b0);
      cycles(TICK * (HOLD + 2));
      check(ind[3-j], 1'b1);
    end
    $display("test indicators done");

    // no write before the first pass: the reset default is under test
    stv = '{8'h10, 8'h01, 8'h02, 8'h20};
    for (int c = 0; c < 4; c++) begin
      if (c != 0) begin
        wb(CFG_OFS, 1'b1, 4'h1, 32'(c) << CFG_CSEL_LSB);
        st <= 8'h10;
        cycles(4);
        check(ind.collision_indicator_n, 1'b1);
      end
      st <= stv[c];
      cycles(4);
      check(ind.collision_indicator_n, 1'b0);
      st <= 8'h00;
      cycles(TICK * (HOLD + 2));
      check(ind.collision_indicator_n, 1'b1);
    end
    wb(CFG_OFS, 1'b0, 4'hF, 32'h0000_0000);
    check(q, 32'h0000_000C);
    $display("test collision select done");

    st <= 8'h80;
    pd_pin <= 1'b1;
    cycles(4);
    check(pd, 1'b1);
    check(ind, 5'h1F);
    pd_pin <= 1'b0;
    wb(CTRL_OFS, 1'b1, 4'h1, 32'h0000_0800);
    check(pd, 1'b0);
    wb(CTRL_OFS, 1'b1, 4'h2, 32'h0000_0800);
    check(pd, 1'b1);
    wb(STATUS_OFS, 1'b0, 4'hF, 32'h0000_0000);
    check(q[STAT_PWRDN_BIT], 1'b1);
    check(q[STAT_RESET_BIT], 1'b0);
    check(q[STAT_SEED_LSB +: 5], STRAP);
    wb(CTRL_OFS, 1'b1, 4'h2, 32'h0000_0000);
    cycles(4);
    check(ind.speed_indicator_n, 1'b0);
    $display("test power down done");

    cfgpin <= 15'h5EC8;
    cycles(4);
    check(cfgpin_state, 10'h0E4);
    wb(CFGPIN_OFS, 1'b0, 4'hF, 32'h0000_0000);
    check(q, 32'h0000_00E4);
    wb(8'h40, 1'b0, 4'hF, 32'h0000_0000);
    check(q, 32'h0000_0000);
    $display("test config pins done");
    stop_test();
  end
endmodule : testbench

/* File: rtl/lamp_stretch.sv */
`timescale 1ns/1ps
module lamp_stretch #(
  parameter int HOLD_TICKS = 5
) (
  // clock and reset
  input  wire logic clk_sys_i,
  input  wire logic reset_n_i,
  // timing
  input  wire logic tick_i,
  // event
  input  wire logic event_i,
  output logic      active_o
);
  import phy_ind_pkg::*;

  localparam int CW = $clog2(HOLD_TICKS + 1);
  localparam logic [CW-1:0] HOLD = CW'(HOLD_TICKS);

  typedef struct packed {
    logic [CW-1:0] cnt;
  } state_t;

  state_t st_reg;
  state_t st_next;

  // reload while the event lasts, decay on each ms tick
  always_comb begin
    st_next = st_reg;
    if (event_i) begin
      st_next.cnt = HOLD;
    end else if (tick_i && st_reg.cnt != '0) begin
      st_next.cnt = st_reg.cnt - CW'(1);
    end
  end

  always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  // short pulses still reach the lamp in the same cycle
  assign active_o = event_i | (st_reg.cnt != '0);

endmodule : lamp_stretch

/* File: rtl/phy_ind_pkg.sv */
package phy_ind_pkg;

  // clock and timing
  localparam int CLK_FREQ_MHZ      = 200;
  localparam int RESET_STRETCH_US  = 300;
  localparam int RESET_STRETCH_CYC = RESET_STRETCH_US * CLK_FREQ_MHZ;
  localparam int LAMP_TICK_US      = 1000;
  localparam int LAMP_TICK_CYC     = LAMP_TICK_US * CLK_FREQ_MHZ;
  localparam int LAMP_HOLD_MS      = 5;

  // register map, byte addresses
  localparam int            WB_AW      = 8;
  localparam logic [7:0]    CTRL_OFS   = 8'h00;
  localparam logic [7:0]    CFG_OFS    = 8'h04;
  localparam logic [7:0]    STATUS_OFS = 8'h08;
  localparam logic [7:0]    CFGPIN_OFS = 8'h0C;

  // field positions
  localparam int CTRL_SOFT_RESET_BIT = 15;
  localparam int CTRL_PWRDN_BIT      = 11;
  localparam int CFG_CSEL_LSB        = 2;
  localparam int STAT_RESET_BIT      = 0;
  localparam int STAT_PWRDN_BIT      = 1;
  localparam int STAT_LINK_BIT       = 2;
  localparam int STAT_SEED_LSB       = 8;

  // configuration pins
  localparam int CFG_PIN_N = 5;
  localparam int LVL_CMP   = 3;

  typedef enum logic [1:0] {
    CSEL_COLLISION   = 2'h0,
    CSEL_FULL_DUPLEX = 2'h1,
    CSEL_LINK        = 2'h2,
    CSEL_ACTIVITY    = 2'h3
  } csel_t;

  localparam csel_t CSEL_RESET = CSEL_COLLISION;

  // gray path hold -> stretch -> run
  typedef enum logic [1:0] {
    RST_HOLD    = 2'h0,
    RST_STRETCH = 2'h1,
    RST_RUN     = 2'h3
  } rst_state_t;

  typedef struct packed {
    logic speed_indicator_n;
    logic receive_activity_indicator_n;
    logic transmit_activity_indicator_n;
    logic link_indicator_n;
    logic collision_indicator_n;
  } indicator_t;

  localparam indicator_t IND_OFF = 5'h1F;

  typedef struct packed {
    logic speed_100;
    logic rx_active;
    logic tx_active;
    logic collision;
    logic descr_lock;
    logic idle_valid;
    logic link_valid_10;
    logic full_duplex;
  } phy_status_t;

  typedef struct packed {
    logic             cyc;
    logic             stb;
    logic             we;
    logic [3:0]       sel;
    logic [WB_AW-1:0] adr;
    logic [31:0]      dat;
  } wb_req_t;

  typedef struct packed {
    logic        ack;
    logic [31:0] dat;
  } wb_rsp_t;

endpackage : phy_ind_pkg

/* File: rtl/phy_indicator_and_reset_control.sv */
// Notes on behaviour
// - speed indicator low when 100 Mbps is selected, high otherwise.
// - receive indicator low while receiver active, high when idle; the code holds it low for up to HOLD_MS ms after activity ends.
// - transmit indicator low while transmitter active, high when idle; the code holds it low for up to HOLD_MS ms after activity ends.
// - at 100 Mbps link indicator low only with descrambler lock and valid idles.
// - at 10 Mbps link indicator low whenever link-valid is true.
// - by default collision indicator low while a collision is seen.
// - software selects what the collision indicator shows via config field.
// - reset when external reset pin low or soft reset bit set, ORed.
// - internal reset cycle lasts 300 us more after reset release.
// - power-down when power-down pin high or power-down bit set, ORed.
// - indicator pin levels sampled during power-up form the scrambler seed.
// - five config inputs, each resolved to four states, lowest is default.
// - register bits are named register.bit, bit numbers 0 to 15.
`timescale 1ns/1ps
module phy_indicator_and_reset_control
  import phy_ind_pkg::*;
#(
  parameter int RST_STRETCH_CYC = phy_ind_pkg::RESET_STRETCH_CYC,
  parameter int MS_TICK_CYC     = phy_ind_pkg::LAMP_TICK_CYC,
  parameter int HOLD_MS         = phy_ind_pkg::LAMP_HOLD_MS
) (
  // clock and reset
  input  wire logic                     clk_sys_i,
  input  wire logic                     reset_n_i,
  // wishbone slave
  input  wire phy_ind_pkg::wb_req_t     wb_req_i,
  output phy_ind_pkg::wb_rsp_t          wb_rsp_o,
  // device pins
  input  wire logic                     ext_reset_n_i,
  input  wire logic                     power_down_input_i,
  input  wire logic [14:0]              multilevel_config_input_i,
  input  wire phy_ind_pkg::indicator_t  ind_i,
  output phy_ind_pkg::indicator_t       ind_o,
  output phy_ind_pkg::indicator_t       ind_oe_n_o,
  // phy core
  input  wire phy_ind_pkg::phy_status_t phy_status_i,
  output logic                          reset_cycle_o,
  output logic                          power_down_o,
  output logic [4:0]                    scrambler_seed_o,
  output logic [9:0]                    cfgpin_state_o
);
  import phy_ind_pkg::*;

  localparam int RW = $clog2(RST_STRETCH_CYC + 1);
  localparam int TW = $clog2(MS_TICK_CYC + 1);
  localparam logic [RW-1:0] RST_LOAD  = RW'(RST_STRETCH_CYC - 1);
  localparam logic [TW-1:0] TICK_LOAD = TW'(MS_TICK_CYC - 1);

  typedef struct packed {
    logic             ext_rst_meta;
    logic             ext_rst_sync;
    logic             pd_meta;
    logic             pd_sync;
    logic [4:0]       ind_meta;
    logic [4:0]       ind_sync;
    logic [14:0]      cfgpin_meta;
    logic [14:0]      cfgpin_sync;
    rst_state_t       rst_state;
    logic [RW-1:0]    rst_cnt;
    logic [TW-1:0]    ms_cnt;
    logic             ms_tick;
    logic             soft_rst;
    logic             pwrdn_bit;
    csel_t            csel;
    logic [4:0]       seed;
    indicator_t       ind;
    logic             wb_ack;
    logic [31:0]      wb_dat;
  } state_t;

  state_t st_reg;
  state_t st_next;

  logic [2:0]       act;
  logic [2:0]       act_lamp;
  logic [4:0][1:0]  cfgpin_state;
  logic             rst_req;
  logic             pd_any;
  logic             live;
  logic             link_up;
  logic             wb_acc;
  logic             wb_wr;

  // thermometer from three comparators; odd codes fall back to default
  function automatic logic [1:0] lvl_resolve(input logic [2:0] t);
    logic [1:0] s;
    case (t)
      3'h1:    s = 2'h1;
      3'h3:    s = 2'h2;
      3'h7:    s = 2'h3;
      default: s = 2'h0;
    endcase
    return s;
  endfunction : lvl_resolve

  genvar g;
  generate
    for (g = 0; g < CFG_PIN_N; g++) begin : g_cfgpin
      assign cfgpin_state[g] = lvl_resolve(st_reg.cfgpin_sync[g*LVL_CMP +: LVL_CMP]);
    end
  endgenerate

  assign act = {phy_status_i.collision, phy_status_i.tx_active, phy_status_i.rx_active};

  generate
    for (g = 0; g < 3; g++) begin : g_lamp
      lamp_stretch #(
        .HOLD_TICKS (HOLD_MS)
      ) u_lamp (
        .clk_sys_i (clk_sys_i),
        .reset_n_i (reset_n_i),
        .tick_i    (st_reg.ms_tick),
        .event_i   (act[g]),
        .active_o  (act_lamp[g])
      );
    end
  endgenerate

  assign rst_req = !st_reg.ext_rst_sync || st_reg.soft_rst;
  assign pd_any  = st_reg.pd_sync || st_reg.pwrdn_bit;
  assign live    = (st_reg.rst_state == RST_RUN) && !pd_any;

  // link qualification differs per speed
  always_comb begin
    if (phy_status_i.speed_100) begin
      link_up = phy_status_i.descr_lock && phy_status_i.idle_valid;
    end else begin
      link_up = phy_status_i.link_valid_10;
    end
  end

  assign wb_acc = wb_req_i.cyc && wb_req_i.stb && !st_reg.wb_ack;
  assign wb_wr  = wb_acc && wb_req_i.we;

  always_comb begin
    st_next = st_reg;

    // two-flop synchronisers for all pins
    st_next.ext_rst_meta = ext_reset_n_i;
    st_next.ext_rst_sync = st_reg.ext_rst_meta;
    st_next.pd_meta      = power_down_input_i;
    st_next.pd_sync      = st_reg.pd_meta;
    st_next.ind_meta     = ind_i;
    st_next.ind_sync     = st_reg.ind_meta;
    st_next.cfgpin_meta  = multilevel_config_input_i;
    st_next.cfgpin_sync  = st_reg.cfgpin_meta;

    // millisecond enable for the lamps
    st_next.ms_tick = 1'b0;
    if (st_reg.ms_cnt == '0) begin
      st_next.ms_cnt  = TICK_LOAD;
      st_next.ms_tick = 1'b1;
    end else begin
      st_next.ms_cnt = st_reg.ms_cnt - TW'(1);
    end

    // reset cycle
    case (st_reg.rst_state)
      RST_HOLD: begin
        st_next.rst_cnt = RST_LOAD;
        if (!rst_req) begin
          st_next.rst_state = RST_STRETCH;
        end
      end
      RST_STRETCH: begin
        if (rst_req) begin
          st_next.rst_state = RST_HOLD;
        end else if (st_reg.rst_cnt == '0) begin
          st_next.rst_state = RST_RUN;
          st_next.seed      = st_reg.ind_sync;
        end else begin
          st_next.rst_cnt = st_reg.rst_cnt - RW'(1);
        end
      end
      RST_RUN: begin
        if (rst_req) begin
          st_next.rst_state = RST_HOLD;
        end
      end
      default: begin
        st_next.rst_state = RST_HOLD;
      end
    endcase

    // soft reset bit clears itself once the hold state is reached
    if (st_reg.rst_state == RST_HOLD) begin
      st_next.soft_rst = 1'b0;
    end

    // indicators; dark in reset cycle and power-down
    st_next.ind = IND_OFF;
    if (live) begin
      st_next.ind.speed_indicator_n             = !phy_status_i.speed_100;
      st_next.ind.receive_activity_indicator_n  = !act_lamp[0];
      st_next.ind.transmit_activity_indicator_n = !act_lamp[1];
      st_next.ind.link_indicator_n              = !link_up;
      case (st_reg.csel)
        CSEL_COLLISION: begin
          st_next.ind.collision_indicator_n = !act_lamp[2];
        end
        CSEL_FULL_DUPLEX: begin
          st_next.ind.collision_indicator_n = !phy_status_i.full_duplex;
        end
        CSEL_LINK: begin
          st_next.ind.collision_indicator_n = !link_up;
        end
        default: begin
          st_next.ind.collision_indicator_n = !(act_lamp[0] || act_lamp[1]);
        end
      endcase
    end

    // wishbone: one wait state, ack for one cycle
    st_next.wb_ack = wb_acc;
    st_next.wb_dat = 32'h0000_0000;
    if (wb_acc && !wb_req_i.we) begin
      case (wb_req_i.adr)
        CTRL_OFS: begin
          st_next.wb_dat[CTRL_SOFT_RESET_BIT] = st_reg.soft_rst;
          st_next.wb_dat[CTRL_PWRDN_BIT]      = st_reg.pwrdn_bit;
        end
        CFG_OFS: begin
          st_next.wb_dat[CFG_CSEL_LSB +: 2] = st_reg.csel;
        end
        STATUS_OFS: begin
          st_next.wb_dat[STAT_RESET_BIT]     = reset_cycle_o;
          st_next.wb_dat[STAT_PWRDN_BIT]     = pd_any;
          st_next.wb_dat[STAT_LINK_BIT]      = link_up;
          st_next.wb_dat[STAT_SEED_LSB +: 5] = st_reg.seed;
        end
        CFGPIN_OFS: begin
          st_next.wb_dat[9:0] = cfgpin_state;
        end
        default: begin
          st_next.wb_dat = 32'h0000_0000;
        end
      endcase
    end
    if (wb_wr) begin
      case (wb_req_i.adr)
        CTRL_OFS: begin
          if (wb_req_i.sel[1]) begin
            st_next.soft_rst  = wb_req_i.dat[CTRL_SOFT_RESET_BIT];
            st_next.pwrdn_bit = wb_req_i.dat[CTRL_PWRDN_BIT];
          end
        end
        CFG_OFS: begin
          if (wb_req_i.sel[0]) begin
            st_next.csel = csel_t'(wb_req_i.dat[CFG_CSEL_LSB +: 2]);
          end
        end
        default: begin
          st_next.csel = st_reg.csel;
        end
      endcase
    end
  end

  always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      st_reg           <= '0;
      st_reg.rst_state <= RST_HOLD;
      st_reg.csel      <= CSEL_RESET;
      st_reg.ind       <= IND_OFF;
      st_reg.rst_cnt   <= RST_LOAD;
    end else begin
      st_reg <= st_next;
    end
  end

  // pins released while straps are read
  assign ind_o            = st_reg.ind;
  assign ind_oe_n_o       = (st_reg.rst_state == RST_RUN) ? '0 : IND_OFF;
  assign reset_cycle_o    = st_reg.rst_state != RST_RUN;
  assign power_down_o     = pd_any;
  assign scrambler_seed_o = st_reg.seed;
  assign cfgpin_state_o   = cfgpin_state;
  assign wb_rsp_o.ack     = st_reg.wb_ack;
  assign wb_rsp_o.dat     = st_reg.wb_dat;

  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (!reset_n_i);

  sequence s_release;
    (st_reg.rst_state == RST_HOLD) ##1 (st_reg.rst_state == RST_STRETCH);
  endsequence

  sequence s_stretch_end;
    (st_reg.rst_state == RST_STRETCH) && !rst_req && (st_reg.rst_cnt == '0);
  endsequence

  // a receive pulse of any length that has just ended
  sequence s_rx_pulse;
    (live && phy_status_i.rx_active) ##1 (live && !phy_status_i.rx_active);
  endsequence

  AST_SPEED: assert property (
      live |=> ind_o.speed_indicator_n == !$past(phy_status_i.speed_100))
    else $error("speed indicator wrong");

  AST_RX: assert property (
      live && phy_status_i.rx_active |=> !ind_o.receive_activity_indicator_n)
    else $error("receive indicator not low");

  AST_RX_HOLD: assert property (
      s_rx_pulse |=> !ind_o.receive_activity_indicator_n)
    else $error("receive pulse not stretched");

  AST_TX: assert property (
      live && phy_status_i.tx_active |=> !ind_o.transmit_activity_indicator_n)
    else $error("transmit indicator not low");

  AST_LINK100: assert property (
      live && phy_status_i.speed_100 |=> ind_o.link_indicator_n ==
      !($past(phy_status_i.descr_lock) && $past(phy_status_i.idle_valid)))
    else $error("link indicator wrong at 100");

  AST_LINK10: assert property (
      live && !phy_status_i.speed_100 |=>
      ind_o.link_indicator_n == !$past(phy_status_i.link_valid_10))
    else $error("link indicator wrong at 10");

  AST_COLL: assert property (
      live && st_reg.csel == CSEL_COLLISION && phy_status_i.collision |=>
      !ind_o.collision_indicator_n)
    else $error("collision indicator not low");

  AST_CSEL_FDX: assert property (
      live && st_reg.csel == CSEL_FULL_DUPLEX |=>
      ind_o.collision_indicator_n == !$past(phy_status_i.full_duplex))
    else $error("collision indicator ignores select");

  AST_RST_OR: assert property (rst_req |=> reset_cycle_o [*2])
    else $error("reset request not honoured");

  AST_STRETCH: assert property (
      s_release |-> reset_cycle_o && st_reg.rst_cnt == RST_LOAD)
    else $error("stretch count not loaded");

  AST_PWRDN: assert property (
      st_reg.pd_sync || st_reg.pwrdn_bit |-> power_down_o ##1 ind_o == IND_OFF)
    else $error("power-down not honoured");

  AST_SEED: assert property (
      s_stretch_end |=> !reset_cycle_o && scrambler_seed_o == $past(st_reg.ind_sync))
    else $error("seed not captured");

endmodule : phy_indicator_and_reset_control
